/* inc/adc_route_pkg.sv */
/*
  package for the right-adc input routing register bank:
  register offsets, field positions, reset values and carrier types.
  assumes a byte-wide register port with 7-bit register index.
*/
package adc_route_pkg;

  // ==========================================================
  // register map
  localparam logic [6:0] second_right_route_addr = 7'h17;
  localparam logic [6:0] first_left_route_addr = 7'h18;

  // ==========================================================
  // field layout
  localparam int diff_bit = 7;
  localparam int level_hi = 6;
  localparam int level_lo = 3;
  localparam int bias_bit = 2;
  // top bit of the reserved low bits of each register
  localparam int rsvd_right_hi = 1;
  localparam int rsvd_left_hi = 2;

  // ==========================================================
  // codes and reset values
  localparam logic [3:0] level_off = 4'hf;
  localparam logic diff_reset = 1'b0;
  localparam logic bias_reset = 1'b0;
  localparam logic [3:0] level_max_code = 4'h8;
  localparam logic [7:0] zero_byte = 8'h00;

  // per-input routing setting
  typedef struct packed {
    logic diff;
    logic [3:0] level;
  } input_route_type;

  // analog control outputs towards the right-adc mixer
  typedef struct packed {
    logic connect;
    logic diff;
    logic [3:0] atten;
  } mixer_ctrl_type;

endpackage : adc_route_pkg

/* rtl/route_decode.sv */
/*
  route_decode: turns one stored routing setting into mixer controls.
  assumes the setting comes from flip-flops in the register bank.
*/
`timescale 1ns/1ps
module route_decode (
  input wire adc_route_pkg::input_route_type setting,
  output adc_route_pkg::mixer_ctrl_type ctrl
);

  // ==========================================================
  // decode
  // any level other than the off code connects the input
  always_comb begin
    ctrl.connect = (setting.level != adc_route_pkg::level_off);
    ctrl.diff = setting.diff;
    ctrl.atten = setting.level;
  end

endmodule : route_decode

/* rtl/right_adc_input_routing_regs.sv */
/*
  right_adc_input_routing_regs: two routing registers steering the
  second right line input and the first left line input into the
  right-adc mixer, plus the weak common-mode bias enable.
  assumes a synchronous byte register port decoded upstream from the
  serial control bus: one-cycle write strobe, read data registered.
*/
// Operation
// - second right line: bit7 differential, resets 0
// - first left line: bit7 differential, resets 0
// - second right level bits6-3, 1.5 dB steps
// - gain code connects; 1111 disconnects, reset 1111
// - first left level: same coding, reset 1111
// - second right bit2 enables weak common-mode bias, resets 0
// - reserved low bits read zero, not writable
`timescale 1ns/1ps
module right_adc_input_routing_regs (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output adc_route_pkg::mixer_ctrl_type second_right_line_input_ctrl,
  output adc_route_pkg::mixer_ctrl_type first_left_line_input_ctrl,
  output logic weak_bias_en
);

  // ==========================================================
  // state
  typedef struct packed {
    adc_route_pkg::input_route_type second_right;
    adc_route_pkg::input_route_type first_left;
    logic bias;
    logic [7:0] rdata;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  // true when the register index names the given register
  function automatic logic reg_hit(input logic [6:0] a, input logic [6:0] target);
    return a == target;
  endfunction : reg_hit

  // assemble a readable byte, reserved low bits forced to zero
  function automatic logic [7:0] pack_route(input adc_route_pkg::input_route_type s, input logic b, input logic has_b);
    logic [7:0] v;
    v = adc_route_pkg::zero_byte;
    v[adc_route_pkg::diff_bit] = s.diff;
    v[adc_route_pkg::level_hi:adc_route_pkg::level_lo] = s.level;
    v[adc_route_pkg::bias_bit] = b & has_b;
    return v;
  endfunction : pack_route

  // ==========================================================
  // next state
  always_comb begin
    state_nxt = state_r;
    if (reg_wr && reg_hit(reg_addr, adc_route_pkg::second_right_route_addr)) begin
      state_nxt.second_right.diff = reg_wdata[adc_route_pkg::diff_bit];
      state_nxt.second_right.level = reg_wdata[adc_route_pkg::level_hi:adc_route_pkg::level_lo];
      state_nxt.bias = reg_wdata[adc_route_pkg::bias_bit];
    end
    if (reg_wr && reg_hit(reg_addr, adc_route_pkg::first_left_route_addr)) begin
      state_nxt.first_left.diff = reg_wdata[adc_route_pkg::diff_bit];
      state_nxt.first_left.level = reg_wdata[adc_route_pkg::level_hi:adc_route_pkg::level_lo];
    end
    // read data: current fields, reserved bits zero, unmapped reads zero
    if (reg_rd) begin
      unique case (reg_addr)
        adc_route_pkg::second_right_route_addr: state_nxt.rdata = pack_route(state_r.second_right, state_r.bias, 1'b1);
        adc_route_pkg::first_left_route_addr: state_nxt.rdata = pack_route(state_r.first_left, 1'b0, 1'b0);
        default: state_nxt.rdata = adc_route_pkg::zero_byte;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r.second_right.diff <= adc_route_pkg::diff_reset;
      state_r.second_right.level <= adc_route_pkg::level_off;
      state_r.first_left.diff <= adc_route_pkg::diff_reset;
      state_r.first_left.level <= adc_route_pkg::level_off;
      state_r.bias <= adc_route_pkg::bias_reset;
      state_r.rdata <= adc_route_pkg::zero_byte;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // outputs
  // mixer controls of the second right line input
  route_decode u_dec_right (
    .setting(state_r.second_right),
    .ctrl(second_right_line_input_ctrl)
  );

  // mixer controls of the first left line input
  route_decode u_dec_left (
    .setting(state_r.first_left),
    .ctrl(first_left_line_input_ctrl)
  );

  assign reg_rdata = state_r.rdata;
  assign weak_bias_en = state_r.bias;

  // ==========================================================
  // assertions
  // second right mode bit follows its write one cycle later
  right_diff_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_hit(reg_addr, adc_route_pkg::second_right_route_addr) |=>
    second_right_line_input_ctrl.diff == $past(reg_wdata[adc_route_pkg::diff_bit]))
    else $error("second right mode not updated");

  // first left mode bit follows its write one cycle later
  left_diff_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_hit(reg_addr, adc_route_pkg::first_left_route_addr) |=>
    first_left_line_input_ctrl.diff == $past(reg_wdata[adc_route_pkg::diff_bit]))
    else $error("first left mode not updated");

  // second right level code reaches the mixer unchanged
  right_level_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_hit(reg_addr, adc_route_pkg::second_right_route_addr) |=>
    second_right_line_input_ctrl.atten == $past(reg_wdata[adc_route_pkg::level_hi:adc_route_pkg::level_lo]))
    else $error("second right level not updated");

  // first left level code reaches the mixer unchanged
  left_level_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_hit(reg_addr, adc_route_pkg::first_left_route_addr) |=>
    first_left_line_input_ctrl.atten == $past(reg_wdata[adc_route_pkg::level_hi:adc_route_pkg::level_lo]))
    else $error("first left level not updated");

  // only the off code leaves the second right input unconnected
  right_connect_a: assert property (@(posedge mclk) disable iff (!rst_n)
    second_right_line_input_ctrl.connect == (second_right_line_input_ctrl.atten != adc_route_pkg::level_off))
    else $error("second right connect mismatch");

  // only the off code leaves the first left input unconnected
  left_connect_a: assert property (@(posedge mclk) disable iff (!rst_n)
    first_left_line_input_ctrl.connect == (first_left_line_input_ctrl.atten != adc_route_pkg::level_off))
    else $error("first left connect mismatch");

  // writing the off code drops the first left input
  left_disconnect_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_hit(reg_addr, adc_route_pkg::first_left_route_addr) &&
    reg_wdata[adc_route_pkg::level_hi:adc_route_pkg::level_lo] == adc_route_pkg::level_off |=>
    !first_left_line_input_ctrl.connect)
    else $error("first left not disconnected");

  // inputs start disconnected, single ended, bias off
  reset_state_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> !second_right_line_input_ctrl.connect && !first_left_line_input_ctrl.connect &&
    !second_right_line_input_ctrl.diff && !first_left_line_input_ctrl.diff && !weak_bias_en)
    else $error("routing not at reset state");

  // bias enable follows bit 2 of the second right register
  bias_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_hit(reg_addr, adc_route_pkg::second_right_route_addr) |=>
    weak_bias_en == $past(reg_wdata[adc_route_pkg::bias_bit]))
    else $error("bias enable not updated");

  // a first left write never touches the bias enable
  bias_kept_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_hit(reg_addr, adc_route_pkg::first_left_route_addr) |=> $stable(weak_bias_en))
    else $error("bias changed by other register");

  // reserved low bits of the first left register read zero
  reserved_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(reg_rd) && reg_hit($past(reg_addr), adc_route_pkg::first_left_route_addr) |->
    reg_rdata[adc_route_pkg::rsvd_left_hi:0] == '0)
    else $error("first left reserved bits not zero");

  // reserved low bits of the second right register read zero
  reserved_right_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(reg_rd) && reg_hit($past(reg_addr), adc_route_pkg::second_right_route_addr) |->
    reg_rdata[adc_route_pkg::rsvd_right_hi:0] == '0)
    else $error("second right reserved bits not zero");

  // readback of the second right level matches the mixer setting
  readback_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && !reg_wr && reg_hit(reg_addr, adc_route_pkg::second_right_route_addr) |=>
    reg_rdata[adc_route_pkg::level_hi:adc_route_pkg::level_lo] == second_right_line_input_ctrl.atten)
    else $error("readback mismatch");

  // without a write the bias enable and the first left level do not move
  hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_wr |=> $stable(weak_bias_en) && $stable(first_left_line_input_ctrl.atten))
    else $error("field changed without write");

  // a second right write leaves the first left setting alone
  left_kept_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_hit(reg_addr, adc_route_pkg::second_right_route_addr) |=>
    $stable(first_left_line_input_ctrl))
    else $error("first left changed by other register");

  // read data stands until the next read strobe
  rdata_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  // ==========================================================
  // cover points
  connect_right_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(second_right_line_input_ctrl.connect));
  connect_left_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(first_left_line_input_ctrl.connect));
  disconnect_right_c: cover property (@(posedge mclk) disable iff (!rst_n) $fell(second_right_line_input_ctrl.connect));
  bias_on_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(weak_bias_en));
  diff_both_c: cover property (@(posedge mclk) disable iff (!rst_n)
    second_right_line_input_ctrl.diff && first_left_line_input_ctrl.diff);

endmodule : right_adc_input_routing_regs

/* bench/right_adc_input_routing_regs_tb.sv */
/*
  testbench for the right-adc input routing register bank.
  assumes the byte register port of the design and 125 MHz mclk.
*/
`timescale 1ns/1ps
module right_adc_input_routing_regs_tb;
  // ==========================================================
  // signals and design
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  adc_route_pkg::mixer_ctrl_type r2_ctrl;
  adc_route_pkg::mixer_ctrl_type l1_ctrl;
  logic weak_bias_en;
  int fails = 0;
  int checks = 0;
  logic [3:0] lv;

  right_adc_input_routing_regs i_right_adc_input_routing_regs (
    .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .second_right_line_input_ctrl(r2_ctrl), .first_left_line_input_ctrl(l1_ctrl),
    .weak_bias_en(weak_bias_en)
  );

  // clock, 8 ns period
  initial begin
    forever #4 mclk = ~mclk;
  end

  // ==========================================================
  // access tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask : chk

  // one write strobe, held for one sampling edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask : wr

  // read strobe, then compare the registered data
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string n);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(posedge mclk);
    #1;
    chk(n, e, reg_rdata);
  endtask : rd

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // tests
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'h1;
    // reset values and disconnected inputs
    rd(7'h17, 8'h78, "right_reset");
    rd(7'h18, 8'h78, "left_reset");
    chk("right_ctrl_reset", 8'h00, {2'h0, r2_ctrl.connect, r2_ctrl.diff, 4'h0});
    chk("left_ctrl_reset", 8'h00, {2'h0, l1_ctrl.connect, l1_ctrl.diff, 4'h0});
    chk("bias_reset", 8'h00, {7'h00, weak_bias_en});
    // every legal gain code, both modes, reserved bits written as zeros
    // each input is routed to this adc only, so no mode pairing is due
    for (int c = 0; c <= 8; c++) begin
      lv = c[3:0];
      wr(7'h17, {lv[0], lv, lv[1], 2'h0});
      wr(7'h18, {~lv[0], lv, 3'h0});
      rd(7'h17, {lv[0], lv, lv[1], 2'h0}, "right");
      rd(7'h18, {~lv[0], lv, 3'h0}, "left");
      chk("right_ctrl", {2'h0, 1'h1, lv[0], lv}, {2'h0, r2_ctrl});
      chk("left_ctrl", {2'h0, 1'h1, ~lv[0], lv}, {2'h0, l1_ctrl});
      chk("bias", {7'h00, lv[1]}, {7'h00, weak_bias_en});
    end
    // disconnect again with code 1111
    wr(7'h17, 8'h7c);
    rd(7'h17, 8'h7c, "right_off");
    chk("right_off_conn", 8'h00, {7'h00, r2_ctrl.connect});
    chk("left_kept", {2'h0, 1'h1, 1'h1, 4'h8}, {2'h0, l1_ctrl});
    // unmapped place is ignored and reads zero
    wr(7'h19, 8'hff);
    rd(7'h19, 8'h00, "unmapped");
    rd(7'h17, 8'h7c, "right_after_unmapped");
    end_of_test();
  end

  // watchdog well beyond the expected run
  initial begin
    #20000;
    fails++;
    end_of_test();
  end
endmodule : right_adc_input_routing_regs_tb
